// ---- pwmi_defines.vh ----
`ifndef PWMI_DEFINES_VH
`define PWMI_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define PWMI_OFS_CTRL 12'h000
`define PWMI_OFS_PERIOD 12'h004
`define PWMI_OFS_STATUS 12'h008
`define PWMI_OFS_WDOG_CTRL 12'h00C
`define PWMI_OFS_WDOG_ARM 12'h010
`define PWMI_OFS_COUNT 12'h014

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define PWMI_CTRL_ENABLE 0
`define PWMI_CTRL_CLKSEL 1
`define PWMI_CTRL_EXTACC 2
`define PWMI_CTRL_PIE 3
`define PWMI_CTRL_LSIE 4
`define PWMI_CTRL_HIGH_TEMP_IRQ_ENABLE 5
`define PWMI_CTRL_TRIM_LSB 8
`define PWMI_CTRL_TRIM_MSB 13

////////////////////////////////////////////////////////////////////////////////
// Status register fields
`define PWMI_STAT_PFLAG 0
`define PWMI_STAT_LSFLAG 1
`define PWMI_STAT_HTFLAG 2
`define PWMI_STAT_LSSTAT 4
`define PWMI_STAT_HTSTAT 5

////////////////////////////////////////////////////////////////////////////////
// Watchdog control fields and arm values
`define PWMI_WDOG_SEL_LSB 0
`define PWMI_WDOG_SEL_MSB 2
`define PWMI_WDOG_WIN 3
`define PWMI_WDOG_LOCK 7
`define PWMI_ARM_FIRST 8'h55
`define PWMI_ARM_SECOND 8'hAA

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define PWMI_RST_CTRL 14'h0000
`define PWMI_RST_PERIOD 16'h0000
`define PWMI_RST_WDOG_SEL 3'h0

////////////////////////////////////////////////////////////////////////////////
// Bus responses
`define PWMI_RESP_OKAY 2'h0
`define PWMI_RESP_SLVERR 2'h2

`endif

// ---- pwmi_period_timer.v ----
`timescale 1ns/1ns
`include "pwmi_defines.vh"
// Reloading down counter of timer ticks
module pwmi_period_timer #(
  parameter WIDTH = 16
) (
  input wire mclk,
  input wire reset_n,
  input wire enable,
  input wire tick,
  input wire [WIDTH-1:0] period,
  output reg [WIDTH-1:0] count,
  output wire expire
);
  reg running;

  // Expiry on the tick that finds the count at zero
  assign expire = enable && running && tick && (count == {WIDTH{1'b0}});

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
      count <= {WIDTH{1'b0}};
    end else if (!enable) begin
      running <= 1'b0;
      count <= {WIDTH{1'b0}};
    end else if (!running) begin
      running <= 1'b1;
      count <= period;
    end else if (expire) begin
      count <= period;
    end else if (tick) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // pwmi_period_timer

// ---- pwmi_sync.v ----
`timescale 1ns/1ns
// Two-flop synchroniser for one comparator level
module pwmi_sync (
  input wire mclk,
  input wire reset_n,
  input wire asyncIn,
  output wire syncOut
);
  reg stage1;
  reg stage2;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
    end
  end

  assign syncOut = stage2;
endmodule // pwmi_sync

// ---- pwmi_top.v ----
`timescale 1ns/1ns
`include "pwmi_defines.vh"
// Contract
// - Low-supply status follows comparator in full performance
// - Any status change sets flag; enable gates request
// - High-temp status follows comparator in full performance
// - Any status change sets flag; enable gates request
// - Timer runs while enabled, starts at enable
// - Clock select picks RC tick or bus clock
// - Bus-clock source frozen while bus clock off
// - Clock select write ignored while enabled
// - Sixteen-bit period writable only while disabled
// - Elapsed period sets flag and restarts timer
// - Periodic request when flag and enable set
// - First period may be lengthened by start-up
// - Waveform pin driven when enabled and externally accessed
// - Arm with 55 then AA; other value resets
module pwmi_top #(
  parameter PERIOD_WIDTH = 16,
  parameter TRIM_WIDTH = 6,
  parameter WDOG_BASE = 32'h0000_0400
) (
  input wire mclk,
  input wire reset_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire fullPerformanceMode,
  input wire supplyBelowLevel,
  input wire tempAboveLevel,
  input wire rcClockTick,
  input wire busClockOn,
  output reg [TRIM_WIDTH-1:0] rcClockTrim,
  output reg periodicWaveformPin,
  output reg lowSupplyIrq,
  output reg highTempIrq,
  output reg periodicIrq,
  output reg watchdogReset
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for register writes
  function [31:0] mergeBytes;
    input [31:0] oldValue;
    input [31:0] newValue;
    input [3:0] strobe;
    integer i;
    begin
      mergeBytes = oldValue;
      for (i = 0; i < 4; i = i + 1) begin
        if (strobe[i]) begin
          mergeBytes[i*8 +: 8] = newValue[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  reg periodic_timer_enable;
  reg periodic_timer_clock_select;
  reg periodic_external_access;
  reg periodic_irq_enable;
  reg low_supply_irq_enable;
  reg high_temp_irq_enable;
  reg [PERIOD_WIDTH-1:0] periodic_timer_period;
  reg periodic_timer_flag;
  reg low_supply_irq_flag;
  reg high_temp_irq_flag;
  reg low_supply_status;
  reg high_temp_status;
  reg [2:0] watchdog_period_select;
  reg watchdog_window_enable;
  reg watchdogLocked;
  reg watchdogArmed;
  reg [31:0] watchdogCount;
  reg waveform;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel capture
  reg awHave;
  reg wHave;
  reg [11:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire doWrite;

  assign s_axi_awready = !awHave;
  assign s_axi_wready = !wHave;
  assign doWrite = awHave && wHave && !s_axi_bvalid;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 12'h000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PWMI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHave) begin
        awHave <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave) begin
        wHave <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr == `PWMI_OFS_CTRL || awAddr == `PWMI_OFS_PERIOD ||
            awAddr == `PWMI_OFS_STATUS || awAddr == `PWMI_OFS_WDOG_CTRL ||
            awAddr == `PWMI_OFS_WDOG_ARM || awAddr == `PWMI_OFS_COUNT) begin
          s_axi_bresp <= `PWMI_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PWMI_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wrCtrl = doWrite && awAddr == `PWMI_OFS_CTRL;
  wire wrPeriod = doWrite && awAddr == `PWMI_OFS_PERIOD;
  wire wrStatus = doWrite && awAddr == `PWMI_OFS_STATUS;
  wire wrWdogCtrl = doWrite && awAddr == `PWMI_OFS_WDOG_CTRL;
  wire wrWdogArm = doWrite && awAddr == `PWMI_OFS_WDOG_ARM && wStrb[0];
  wire [31:0] ctrlMerged = mergeBytes(32'h0000_0000, wData, wStrb);
  wire [31:0] periodMerged = mergeBytes({{(32-PERIOD_WIDTH){1'b0}}, periodic_timer_period}, wData, wStrb);

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers
  wire [1:0] compRaw = {tempAboveLevel, supplyBelowLevel};
  wire [1:0] compSync;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gSync
      pwmi_sync uSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .asyncIn(compRaw[g]),
        .syncOut(compSync[g])
      );
    end
  endgenerate

  // Status follows comparator only in full performance mode
  wire next_low_supply_status =
    fullPerformanceMode ? compSync[0] : low_supply_status;
  wire next_high_temp_status =
    fullPerformanceMode ? compSync[1] : high_temp_status;
  wire lowSupplyChange = next_low_supply_status != low_supply_status;
  wire highTempChange = next_high_temp_status != high_temp_status;

  ////////////////////////////////////////////////////////////////////////////
  // Periodic timer
  wire timerTick;
  wire timerExpire;
  wire [PERIOD_WIDTH-1:0] timerCount;

  // Bus clock source stalls while the bus clock is off
  assign timerTick = periodic_timer_clock_select ? busClockOn : rcClockTick;

  pwmi_period_timer #(
    .WIDTH(PERIOD_WIDTH)
  ) uTimer (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(periodic_timer_enable),
    .tick(timerTick),
    .period(periodic_timer_period),
    .count(timerCount),
    .expire(timerExpire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control and status registers
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      periodic_timer_enable <= 1'b0;
      periodic_timer_clock_select <= 1'b0;
      periodic_external_access <= 1'b0;
      periodic_irq_enable <= 1'b0;
      low_supply_irq_enable <= 1'b0;
      high_temp_irq_enable <= 1'b0;
      rcClockTrim <= {TRIM_WIDTH{1'b0}};
      periodic_timer_period <= `PWMI_RST_PERIOD;
      periodic_timer_flag <= 1'b0;
      low_supply_irq_flag <= 1'b0;
      high_temp_irq_flag <= 1'b0;
      low_supply_status <= 1'b0;
      high_temp_status <= 1'b0;
      waveform <= 1'b0;
    end else begin
      if (wrCtrl && wStrb[0]) begin
        periodic_timer_enable <= ctrlMerged[`PWMI_CTRL_ENABLE];
        if (!periodic_timer_enable) begin
          periodic_timer_clock_select <= ctrlMerged[`PWMI_CTRL_CLKSEL];
        end
        periodic_external_access <= ctrlMerged[`PWMI_CTRL_EXTACC];
        periodic_irq_enable <= ctrlMerged[`PWMI_CTRL_PIE];
        low_supply_irq_enable <= ctrlMerged[`PWMI_CTRL_LSIE];
        high_temp_irq_enable <= ctrlMerged[`PWMI_CTRL_HIGH_TEMP_IRQ_ENABLE];
      end
      if (wrCtrl && wStrb[1]) begin
        rcClockTrim <= ctrlMerged[`PWMI_CTRL_TRIM_MSB:`PWMI_CTRL_TRIM_LSB];
      end
      if (wrPeriod && !periodic_timer_enable) begin
        periodic_timer_period <= periodMerged[PERIOD_WIDTH-1:0];
      end
      low_supply_status <= next_low_supply_status;
      high_temp_status <= next_high_temp_status;
      // Hardware set wins over a write-one clear in the same cycle
      periodic_timer_flag <= timerExpire ||
        (periodic_timer_flag && !(wrStatus && wStrb[0] &&
        wData[`PWMI_STAT_PFLAG]));
      low_supply_irq_flag <= lowSupplyChange ||
        (low_supply_irq_flag && !(wrStatus && wStrb[0] &&
        wData[`PWMI_STAT_LSFLAG]));
      high_temp_irq_flag <= highTempChange ||
        (high_temp_irq_flag && !(wrStatus && wStrb[0] &&
        wData[`PWMI_STAT_HTFLAG]));
      if (!periodic_timer_enable) begin
        waveform <= 1'b0;
      end else if (timerExpire) begin
        waveform <= !waveform;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  wire [31:0] wdTimeout = WDOG_BASE << {watchdog_period_select, 1'b0};
  wire wdRunning = watchdog_period_select != 3'h0;
  wire [31:0] wdWindowStart = wdTimeout - (wdTimeout >> 2);
  wire [7:0] armByte = wData[7:0];
  wire armGood = armByte == `PWMI_ARM_FIRST || armByte == `PWMI_ARM_SECOND;
  wire armEarly = watchdog_window_enable && watchdogCount < wdWindowStart;
  wire wdBadWrite = wdRunning && wrWdogArm && (!armGood || armEarly);
  wire wdTimeoutHit = wdRunning && watchdogCount >= wdTimeout - 32'h0000_0001;
  wire wdRestart = wdRunning && wrWdogArm && !wdBadWrite && watchdogArmed &&
    armByte == `PWMI_ARM_SECOND;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_period_select <= `PWMI_RST_WDOG_SEL;
      watchdog_window_enable <= 1'b0;
      watchdogLocked <= 1'b0;
      watchdogArmed <= 1'b0;
      watchdogCount <= 32'h0000_0000;
      watchdogReset <= 1'b0;
    end else begin
      // One configuration write is taken, then the fields lock
      if (wrWdogCtrl && wStrb[0] && !watchdogLocked) begin
        watchdog_period_select <= wData[`PWMI_WDOG_SEL_MSB:`PWMI_WDOG_SEL_LSB];
        watchdog_window_enable <= wData[`PWMI_WDOG_WIN];
        watchdogLocked <= 1'b1;
      end
      watchdogReset <= wdBadWrite || wdTimeoutHit;
      if (!wdRunning || wdBadWrite || wdTimeoutHit || wdRestart) begin
        watchdogCount <= 32'h0000_0000;
        watchdogArmed <= 1'b0;
      end else begin
        watchdogCount <= watchdogCount + 32'h0000_0001;
        if (wrWdogArm) begin
          watchdogArmed <= armByte == `PWMI_ARM_FIRST;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lowSupplyIrq <= 1'b0;
      highTempIrq <= 1'b0;
      periodicIrq <= 1'b0;
      periodicWaveformPin <= 1'b0;
    end else begin
      lowSupplyIrq <= low_supply_irq_flag && low_supply_irq_enable;
      highTempIrq <= high_temp_irq_flag && high_temp_irq_enable;
      periodicIrq <= periodic_timer_flag && periodic_irq_enable;
      periodicWaveformPin <= waveform && periodic_timer_enable &&
        periodic_external_access;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `PWMI_RESP_OKAY;
    if (s_axi_araddr == `PWMI_OFS_CTRL) begin
      next_rdata[`PWMI_CTRL_ENABLE] = periodic_timer_enable;
      next_rdata[`PWMI_CTRL_CLKSEL] = periodic_timer_clock_select;
      next_rdata[`PWMI_CTRL_EXTACC] = periodic_external_access;
      next_rdata[`PWMI_CTRL_PIE] = periodic_irq_enable;
      next_rdata[`PWMI_CTRL_LSIE] = low_supply_irq_enable;
      next_rdata[`PWMI_CTRL_HIGH_TEMP_IRQ_ENABLE] = high_temp_irq_enable;
      next_rdata[`PWMI_CTRL_TRIM_MSB:`PWMI_CTRL_TRIM_LSB] = rcClockTrim;
    end else if (s_axi_araddr == `PWMI_OFS_PERIOD) begin
      next_rdata[PERIOD_WIDTH-1:0] = periodic_timer_period;
    end else if (s_axi_araddr == `PWMI_OFS_STATUS) begin
      next_rdata[`PWMI_STAT_PFLAG] = periodic_timer_flag;
      next_rdata[`PWMI_STAT_LSFLAG] = low_supply_irq_flag;
      next_rdata[`PWMI_STAT_HTFLAG] = high_temp_irq_flag;
      next_rdata[`PWMI_STAT_LSSTAT] = low_supply_status;
      next_rdata[`PWMI_STAT_HTSTAT] = high_temp_status;
    end else if (s_axi_araddr == `PWMI_OFS_WDOG_CTRL) begin
      next_rdata[`PWMI_WDOG_SEL_MSB:`PWMI_WDOG_SEL_LSB] = watchdog_period_select;
      next_rdata[`PWMI_WDOG_WIN] = watchdog_window_enable;
      next_rdata[`PWMI_WDOG_LOCK] = watchdogLocked;
    end else if (s_axi_araddr == `PWMI_OFS_WDOG_ARM) begin
      next_rdata = 32'h0000_0000;
    end else if (s_axi_araddr == `PWMI_OFS_COUNT) begin
      next_rdata[PERIOD_WIDTH-1:0] = timerCount;
    end else begin
      next_rresp = `PWMI_RESP_SLVERR;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PWMI_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pwmi_top

// ---- pwmi_top_asserts.sv ----
`timescale 1ns/1ns
module pwmi_top_asserts (
  input wire mclk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire supplyBelowLevel,
  input wire tempAboveLevel,
  input wire fullPerformanceMode,
  input wire lowSupplyIrq,
  input wire highTempIrq,
  input wire periodicIrq,
  input wire watchdogReset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////
  // Handshake steps
  sequence s_wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wrDone;
    ##2 s_axi_bvalid;
  endsequence
  property p_wrResp;
    s_wrTaken |-> s_wrDone;
  endproperty
  property p_rdResp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  ////////////////
  // Event outputs
  property p_wdogPulse;
    watchdogReset |=> !watchdogReset;
  endproperty
  property p_lsCause;
    $rose(lowSupplyIrq) |->
      $past(s_axi_bvalid) || ($past(supplyBelowLevel, 4) != $past(supplyBelowLevel, 5)) ||
      ($past(fullPerformanceMode, 2) && !$past(fullPerformanceMode, 3));
  endproperty
  property p_htCause;
    $rose(highTempIrq) |->
      $past(s_axi_bvalid) || ($past(tempAboveLevel, 4) != $past(tempAboveLevel, 5)) ||
      ($past(fullPerformanceMode, 2) && !$past(fullPerformanceMode, 3));
  endproperty
  property p_perFall;
    $fell(periodicIrq) |-> $past(s_axi_bvalid);
  endproperty
  a_wrResp: assert property (p_wrResp) else $error("write response late");
  a_rdResp: assert property (p_rdResp) else $error("read response late");
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  a_rHold: assert property (p_rHold) else $error("read data dropped");
  a_wdogPulse: assert property (p_wdogPulse) else $error("reset pulse too long");
  a_lsCause: assert property (p_lsCause) else $error("low supply irq no cause");
  a_htCause: assert property (p_htCause) else $error("high temp irq no cause");
  a_perFall: assert property (p_perFall) else $error("periodic irq lost");
endmodule // pwmi_top_asserts
bind pwmi_top pwmi_top_asserts i_pwmi_top_asserts (.mclk(mclk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .supplyBelowLevel(supplyBelowLevel), .tempAboveLevel(tempAboveLevel),
  .fullPerformanceMode(fullPerformanceMode),
  .lowSupplyIrq(lowSupplyIrq), .highTempIrq(highTempIrq), .periodicIrq(periodicIrq),
  .watchdogReset(watchdogReset));

// ---- pwmi_top_bench.sv ----
`timescale 1ns/1ns
`include "pwmi_defines.vh"
module pwmi_top_bench;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic [11:0] awAddr = 12'h000;
  logic [11:0] arAddr = 12'h000;
  logic [31:0] wData = 32'h0000_0000;
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
  logic fullPerf = 1'h1, rcTick = 1'h0, busOn = 1'h1;
  logic [1:0] cmp = 2'h0;
  wire awReady, wReady, bValid, arReady, rValid, wavePin, pIrq, wdRst;
  wire [1:0] bResp, rResp, monIrq;
  wire [31:0] rData;
  wire [5:0] trim;
  int fails = 0, nTests = 0, wdHits = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (wdRst) wdHits <= wdHits + 1;
  pwmi_top #(.WDOG_BASE(4)) i_pwmi_top (.mclk(mclk), .reset_n(reset_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .fullPerformanceMode(fullPerf), .supplyBelowLevel(cmp[0]), .tempAboveLevel(cmp[1]),
    .rcClockTick(rcTick), .busClockOn(busOn), .rcClockTrim(trim),
    .periodicWaveformPin(wavePin), .lowSupplyIrq(monIrq[0]), .highTempIrq(monIrq[1]),
    .periodicIrq(pIrq), .watchdogReset(wdRst));
  ////////////////
  // Common tasks
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input logic p);
    if (p) begin
      fails++;
      $display("[ERR] handshake expected answer seen none");
      wrap_up();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      rcTick <= 1'h1;
      @(posedge mclk);
      rcTick <= 1'h0;
      @(posedge mclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic pa, pw, pb;
    n = 0;
    pa = 1'h1;
    pw = 1'h1;
    pb = 1'h1;
    awAddr <= a;
    wData <= d;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    while (pb && n < 50) begin
      @(posedge mclk);
      n++;
      if (pa && awReady) begin
        pa = 1'h0;
        awValid <= 1'h0;
      end
      if (pw && wReady) begin
        pw = 1'h0;
        wValid <= 1'h0;
      end
      if (bValid) begin
        pb = 1'h0;
        rs = bResp;
        bReady <= 1'h0;
      end
    end
    hang(pb);
    @(posedge mclk);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    int n;
    logic pa, pb;
    n = 0;
    pa = 1'h1;
    pb = 1'h1;
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    while (pb && n < 50) begin
      @(posedge mclk);
      n++;
      if (pa && arReady) begin
        pa = 1'h0;
        arValid <= 1'h0;
      end
      if (rValid) begin
        pb = 1'h0;
        rd = rData;
        rs = rResp;
        rReady <= 1'h0;
      end
    end
    hang(pb);
    @(posedge mclk);
    chk(nm, e, rd);
  endtask
  task automatic pinToggles(output int t);
    logic last;
    t = 0;
    last = wavePin;
    repeat (16) begin
      @(posedge mclk);
      if (wavePin !== last) t++;
      last = wavePin;
    end
  endtask
  ////////////////
  // Scenarios
  task automatic tRegs;
    rchk("ctrlReset", `PWMI_OFS_CTRL, 32'h0000_0000);
    rchk("periodReset", `PWMI_OFS_PERIOD, 32'h0000_0000);
    rchk("statusReset", `PWMI_OFS_STATUS, 32'h0000_0000);
    rchk("unmappedData", 12'h03C, 32'h0000_0000);
    chk("unmappedResp", 32'(`PWMI_RESP_SLVERR), 32'(rs));
    wr(12'h03C, 32'h0000_00FF);
    chk("unmappedWrResp", 32'(`PWMI_RESP_SLVERR), 32'(rs));
    wr(`PWMI_OFS_CTRL, 32'h0000_2A00);
    chk("trimPort", 32'h0000_002A, 32'(trim));
    rchk("trimRead", `PWMI_OFS_CTRL, 32'h0000_2A00);
    wr(`PWMI_OFS_CTRL, 32'h0000_0000);
    $display("registers done");
  endtask
  task automatic tMon;
    for (int i = 0; i < 2; i++) begin
      wr(`PWMI_OFS_CTRL, 32'h0000_0030);
      cmp[i] <= 1'h1;
      cyc(6);
      rchk("monRise", `PWMI_OFS_STATUS, 32'h0000_0012 << i);
      chk("monIrqOn", 32'h0000_0001, 32'(monIrq[i]));
      wr(`PWMI_OFS_STATUS, 32'h0000_0006);
      rchk("monOnce", `PWMI_OFS_STATUS, 32'h0000_0010 << i);
      wr(`PWMI_OFS_CTRL, 32'h0000_0000);
      cmp[i] <= 1'h0;
      cyc(6);
      rchk("monFall", `PWMI_OFS_STATUS, 32'h0000_0002 << i);
      chk("monMasked", 32'h0000_0000, 32'(monIrq[i]));
      wr(`PWMI_OFS_STATUS, 32'h0000_0006);
    end
    fullPerf <= 1'h0;
    cmp <= 2'h3;
    cyc(6);
    rchk("monIdle", `PWMI_OFS_STATUS, 32'h0000_0000);
    cmp <= 2'h0;
    cyc(6);
    fullPerf <= 1'h1;
    $display("monitors done");
  endtask
  task automatic tTimer;
    wr(`PWMI_OFS_PERIOD, 32'h0000_0003);
    wr(`PWMI_OFS_CTRL, 32'h0000_0009);
    ticks(3);
    rchk("flagEarly", `PWMI_OFS_STATUS, 32'h0000_0000);
    ticks(1);
    cyc(2);
    rchk("flagSet", `PWMI_OFS_STATUS, 32'h0000_0001);
    chk("irqSet", 32'h0000_0001, 32'(pIrq));
    wr(`PWMI_OFS_PERIOD, 32'h0000_0007);
    rchk("periodLocked", `PWMI_OFS_PERIOD, 32'h0000_0003);
    wr(`PWMI_OFS_CTRL, 32'h0000_000B);
    rchk("selectLocked", `PWMI_OFS_CTRL, 32'h0000_0009);
    wr(`PWMI_OFS_STATUS, 32'h0000_0001);
    rchk("flagCleared", `PWMI_OFS_STATUS, 32'h0000_0000);
    chk("irqCleared", 32'h0000_0000, 32'(pIrq));
    ticks(3);
    rchk("noEarlyRestart", `PWMI_OFS_STATUS, 32'h0000_0000);
    ticks(1);
    cyc(2);
    rchk("restarted", `PWMI_OFS_STATUS, 32'h0000_0001);
    wr(`PWMI_OFS_CTRL, 32'h0000_0000);
    wr(`PWMI_OFS_STATUS, 32'h0000_0001);
    ticks(5);
    rchk("stopped", `PWMI_OFS_STATUS, 32'h0000_0000);
    $display("timer done");
  endtask
  task automatic tBusClk;
    int t;
    busOn <= 1'h0;
    wr(`PWMI_OFS_CTRL, 32'h0000_0002);
    wr(`PWMI_OFS_CTRL, 32'h0000_0007);
    cyc(20);
    rchk("frozen", `PWMI_OFS_STATUS, 32'h0000_0000);
    busOn <= 1'h1;
    cyc(6);
    rchk("busTick", `PWMI_OFS_STATUS, 32'h0000_0001);
    pinToggles(t);
    chk("pinActive", 32'h0000_0001, 32'(t >= 3));
    wr(`PWMI_OFS_CTRL, 32'h0000_0003);
    cyc(2);
    pinToggles(t);
    chk("pinQuiet", 32'h0000_0000, 32'(t));
    wr(`PWMI_OFS_CTRL, 32'h0000_0002);
    wr(`PWMI_OFS_STATUS, 32'h0000_0001);
    $display("bus clock done");
  endtask
  task automatic tWdog;
    int h;
    chk("wdogIdle", 32'h0000_0000, 32'(wdHits));
    wr(`PWMI_OFS_WDOG_CTRL, 32'h0000_0001);
    wr(`PWMI_OFS_WDOG_ARM, 32'h0000_0055);
    wr(`PWMI_OFS_WDOG_ARM, 32'h0000_00AA);
    chk("armedOk", 32'h0000_0000, 32'(wdHits));
    h = wdHits;
    wr(`PWMI_OFS_WDOG_ARM, 32'h0000_0012);
    cyc(2);
    chk("badArm", 32'(h + 1), 32'(wdHits));
    wr(`PWMI_OFS_WDOG_CTRL, 32'h0000_0000);
    rchk("wdogOnce", `PWMI_OFS_WDOG_CTRL, 32'h0000_0081);
    h = wdHits;
    cyc(40);
    chk("wdogExpired", 32'h0000_0001, 32'(wdHits > h));
    $display("watchdog done");
  endtask
  ////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    tRegs();
    tMon();
    tTimer();
    tBusClk();
    tWdog();
    wrap_up();
  end
endmodule // pwmi_top_bench
